// [design/timer_master_trigger_select.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Select bit 0 routes the channel 0 pin alone to channel 0 trigger input.
// - Select bit 1 routes XOR of channel 0, 1 and 2 pins instead.
// - Three-bit master mode field picks the event driving the trigger output.
// - Code 000 pulses trigger output on counter reset or update generation.
// - Code 001 asserts trigger output on counter run or trigger high in pause.
// - Code 010 pulses trigger output on channel 0 capture or compare events.
// - Code 110 drives trigger output from channel 2 compare reference.
// - DMA source bit 0: each channel requests DMA on its capture/compare event.
// - DMA source bit 1: each channel requests DMA on the update event.
// - Control register at 0x04, resets to zero, reserved bits stay zero.

module timer_master_trigger_select #(
  parameter int CHANNELS = 4
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic CHANNEL0_PIN,
  input wire logic CHANNEL1_PIN,
  input wire logic CHANNEL2_PIN,
  input wire logic COUNTER_RESET_EVENT,
  input wire logic UPDATE_GENERATION_BIT,
  input wire logic COUNTER_RUN_BIT,
  input wire logic PAUSE_MODE,
  input wire logic TRIGGER_INPUT,
  input wire logic UPDATE_EVENT,
  input wire logic [CHANNELS-1:0] CAPCMP_EVENT,
  input wire logic [3:0] COMPARE_REFERENCE,
  output logic CH0_TRIGGER_INPUT,
  output logic TRIGGER_OUTPUT,
  output logic [CHANNELS-1:0] DMA_REQUEST
);

  function automatic logic [1:0] decode_addr(input logic [7:0] addr);
    if (addr[7:2] == timer_trigger_pkg::CTL1_OFFSET[7:2]) begin
      decode_addr = timer_trigger_pkg::SEL_CTL1;
    end else if (addr[7:2] == timer_trigger_pkg::STATUS_OFFSET[7:2]) begin
      decode_addr = timer_trigger_pkg::SEL_STATUS;
    end else begin
      decode_addr = timer_trigger_pkg::SEL_NONE;
    end
  endfunction : decode_addr

  // Control fields
  logic trig_sel_reg;
  logic trig_sel_next;
  logic [2:0] mm_reg;
  logic [2:0] mm_next;
  logic dma_src_reg;
  logic dma_src_next;

  // Write channel state
  logic aw_held_reg;
  logic aw_held_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic w_held_reg;
  logic w_held_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0] w_strb_reg;
  logic [3:0] w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Read channel state
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic rd_ctl_reg;
  logic rd_ctl_next;

  // Channel DMA requests
  logic [CHANNELS-1:0] dma_reg;
  logic [CHANNELS-1:0] dma_next;

  logic do_write;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic [31:0] ctl1_word;
  logic [31:0] status_word;
  logic trig_out;

  assign AWREADY = !aw_held_reg && !bvalid_reg;
  assign WREADY = !w_held_reg && !bvalid_reg;
  assign ARREADY = !rvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_sel = decode_addr(aw_addr_reg);
  assign rd_sel = decode_addr(ARADDR);

  // Combinational path: the trigger input feeds edge logic with no extra delay
  assign CH0_TRIGGER_INPUT = trig_sel_reg ? (CHANNEL0_PIN ^ CHANNEL1_PIN ^ CHANNEL2_PIN) : CHANNEL0_PIN;

  always_comb begin
    ctl1_word = timer_trigger_pkg::CTL1_RESET;
    ctl1_word[timer_trigger_pkg::TRIG_SEL_BIT] = trig_sel_reg;
    ctl1_word[timer_trigger_pkg::MM_MSB:timer_trigger_pkg::MM_LSB] = mm_reg;
    ctl1_word[timer_trigger_pkg::DMA_SRC_BIT] = dma_src_reg;
    status_word = 32'h00000000;
    status_word[timer_trigger_pkg::ST_TRIG_OUT_BIT] = trig_out;
    status_word[timer_trigger_pkg::ST_DMA_LSB +: 4] = 4'(dma_reg);
    status_word[timer_trigger_pkg::ST_CH0_TRIG_BIT] = CH0_TRIGGER_INPUT;
  end

  // Write path; address and data may arrive in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    trig_sel_next = trig_sel_reg;
    mm_next = mm_reg;
    dma_src_next = dma_src_reg;
    if (AWVALID && AWREADY) begin
      aw_held_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_held_next = 1'b1;
      w_data_next = WDATA;
      w_strb_next = WSTRB;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = timer_trigger_pkg::RESP_OKAY;
      // Only the low byte carries fields; reserved bits are never stored
      if (wr_sel == timer_trigger_pkg::SEL_CTL1 && w_strb_reg[0]) begin
        trig_sel_next = w_data_reg[timer_trigger_pkg::TRIG_SEL_BIT];
        mm_next = w_data_reg[timer_trigger_pkg::MM_MSB:timer_trigger_pkg::MM_LSB];
        dma_src_next = w_data_reg[timer_trigger_pkg::DMA_SRC_BIT];
      end else if (wr_sel == timer_trigger_pkg::SEL_NONE) begin
        bresp_next = timer_trigger_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_reg && BREADY) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      trig_sel_reg <= 1'b0;
      mm_reg <= 3'h0;
      dma_src_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      trig_sel_reg <= trig_sel_next;
      mm_reg <= mm_next;
      dma_src_reg <= dma_src_next;
    end
  end

  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;

  // Read path; data is captured when the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_ctl_next = rd_ctl_reg;
    if (ARVALID && ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = timer_trigger_pkg::RESP_OKAY;
      rd_ctl_next = rd_sel == timer_trigger_pkg::SEL_CTL1;
      case (rd_sel)
        timer_trigger_pkg::SEL_CTL1: rdata_next = ctl1_word;
        timer_trigger_pkg::SEL_STATUS: rdata_next = status_word;
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = timer_trigger_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
      rd_ctl_reg <= 1'b0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rd_ctl_reg <= rd_ctl_next;
    end
  end

  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;

  // DMA request source
  always_comb begin
    if (dma_src_reg) begin
      dma_next = {CHANNELS{UPDATE_EVENT}};
    end else begin
      dma_next = CAPCMP_EVENT;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      dma_reg <= '0;
    end else begin
      dma_reg <= dma_next;
    end
  end

  assign DMA_REQUEST = dma_reg;

  trigger_output_select u_trigger_output_select (
    .clk(CLK_SYS),
    .rst(RESET),
    .mode(mm_reg),
    .counter_reset(COUNTER_RESET_EVENT),
    .update_generation_bit(UPDATE_GENERATION_BIT),
    .counter_run_bit(COUNTER_RUN_BIT),
    .pause_mode(PAUSE_MODE),
    .trigger_input(TRIGGER_INPUT),
    .ch0_capcmp(CAPCMP_EVENT[0]),
    .update_event(UPDATE_EVENT),
    .compare_reference(COMPARE_REFERENCE),
    .trigger_output(trig_out)
  );

  assign TRIGGER_OUTPUT = trig_out;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  logic wr_ctl_hit;
  assign wr_ctl_hit = do_write && wr_sel == timer_trigger_pkg::SEL_CTL1 && w_strb_reg[0];

  chk_pin_direct: assert property (!trig_sel_reg |-> CH0_TRIGGER_INPUT == CHANNEL0_PIN)
    else $error("channel 0 trigger input not the pin");

  chk_pin_xor: assert property (trig_sel_reg |->
    CH0_TRIGGER_INPUT == (CHANNEL0_PIN ^ CHANNEL1_PIN ^ CHANNEL2_PIN))
    else $error("channel 0 trigger input not the xor");

  sequence mode_write_s;
    wr_ctl_hit ##1 1'b1;
  endsequence

  chk_mode_field: assert property (mode_write_s |->
    mm_reg == $past(w_data_reg[timer_trigger_pkg::MM_MSB:timer_trigger_pkg::MM_LSB]))
    else $error("master mode field not loaded");

  sequence ctl_read_s;
    ARVALID && ARREADY && rd_sel == timer_trigger_pkg::SEL_CTL1 ##1 1'b1;
  endsequence

  chk_mode_readback: assert property (ctl_read_s |->
    rdata_reg[timer_trigger_pkg::MM_MSB:timer_trigger_pkg::MM_LSB] == $past(mm_reg))
    else $error("mode readback differs from stored field");

  sequence reset_event_s;
    mm_reg == timer_trigger_pkg::MM_RESET && (COUNTER_RESET_EVENT || UPDATE_GENERATION_BIT);
  endsequence

  chk_reset_pulse: assert property (reset_event_s ##1 (mm_reg == timer_trigger_pkg::MM_RESET)
    |-> TRIGGER_OUTPUT)
    else $error("no trigger pulse on counter reset");

  chk_start_level: assert property (mm_reg == timer_trigger_pkg::MM_START &&
    (COUNTER_RUN_BIT || (PAUSE_MODE && TRIGGER_INPUT)) ##1 mm_reg == timer_trigger_pkg::MM_START
    |-> TRIGGER_OUTPUT)
    else $error("trigger output missing on counter start");

  chk_capcmp_pulse: assert property (mm_reg == timer_trigger_pkg::MM_CH0_CAPCMP && CAPCMP_EVENT[0]
    ##1 mm_reg == timer_trigger_pkg::MM_CH0_CAPCMP |-> TRIGGER_OUTPUT)
    else $error("no trigger pulse on channel 0 event");

  chk_ref2_follow: assert property (mm_reg == timer_trigger_pkg::MM_REF2
    ##1 mm_reg == timer_trigger_pkg::MM_REF2 |-> TRIGGER_OUTPUT == $past(COMPARE_REFERENCE[2]))
    else $error("trigger output not following channel 2 reference");

  chk_pulse_width: assert property (mm_reg == timer_trigger_pkg::MM_RESET &&
    !COUNTER_RESET_EVENT && !UPDATE_GENERATION_BIT ##1 mm_reg == timer_trigger_pkg::MM_RESET
    |-> !TRIGGER_OUTPUT)
    else $error("trigger pulse without a reset event");

  chk_ref0_map: assert property (mm_reg == timer_trigger_pkg::MM_REF0
    ##1 mm_reg == timer_trigger_pkg::MM_REF0 |-> TRIGGER_OUTPUT == $past(COMPARE_REFERENCE[0]))
    else $error("code 100 not mapped to channel 0 reference");

  chk_dma_capcmp: assert property (!dma_src_reg ##1 1'b1 |-> DMA_REQUEST == $past(CAPCMP_EVENT))
    else $error("dma request not from capture compare");

  chk_dma_update: assert property (dma_src_reg ##1 1'b1 |->
    DMA_REQUEST == {CHANNELS{$past(UPDATE_EVENT)}})
    else $error("dma request not from update event");

  chk_reserved_zero: assert property (rvalid_reg && rd_ctl_reg |->
    (rdata_reg & ~timer_trigger_pkg::CTL1_WRITABLE) == 32'h00000000)
    else $error("reserved control bits read nonzero");

  chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##1 do_write ##1 BVALID)
    else $error("write response not two cycles after taking");

  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer not one cycle after address");

endmodule : timer_master_trigger_select

`default_nettype wire

// [design/timer_trigger_pkg.sv]
package timer_trigger_pkg;

  // Register map, byte addresses on the 32-bit bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTL1_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h0C;
  localparam logic [31:0] CTL1_RESET = 32'h00000000;

  // Control register 1 field positions
  localparam int TRIG_SEL_BIT = 7;
  localparam int MM_LSB = 4;
  localparam int MM_MSB = 6;
  localparam int DMA_SRC_BIT = 3;
  localparam logic [31:0] CTL1_WRITABLE = 32'h000000F8;

  // Status register field positions
  localparam int ST_TRIG_OUT_BIT = 0;
  localparam int ST_DMA_LSB = 1;
  localparam int ST_CH0_TRIG_BIT = 5;

  // Master mode codes
  localparam logic [2:0] MM_RESET = 3'h0;
  localparam logic [2:0] MM_START = 3'h1;
  localparam logic [2:0] MM_CH0_CAPCMP = 3'h2;
  localparam logic [2:0] MM_UPDATE = 3'h3;
  localparam logic [2:0] MM_REF0 = 3'h4;
  localparam logic [2:0] MM_REF1 = 3'h5;
  localparam logic [2:0] MM_REF2 = 3'h6;
  localparam logic [2:0] MM_REF3 = 3'h7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Address decode results
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTL1 = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;

endpackage : timer_trigger_pkg

// [design/trigger_output_select.sv]
`timescale 1ns/1ps
`default_nettype none

module trigger_output_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] mode,
  input wire logic counter_reset,
  input wire logic update_generation_bit,
  input wire logic counter_run_bit,
  input wire logic pause_mode,
  input wire logic trigger_input,
  input wire logic ch0_capcmp,
  input wire logic update_event,
  input wire logic [3:0] compare_reference,
  output logic trigger_output
);

  logic trig_reg;
  logic trig_next;

  // Output is the selected source registered one cycle late, so it is one cycle wide only when that source is a single-cycle pulse
  always_comb begin
    case (mode)
      timer_trigger_pkg::MM_RESET: trig_next = counter_reset | update_generation_bit;
      timer_trigger_pkg::MM_START: trig_next = counter_run_bit | (pause_mode & trigger_input);
      timer_trigger_pkg::MM_CH0_CAPCMP: trig_next = ch0_capcmp;
      timer_trigger_pkg::MM_UPDATE: trig_next = update_event;
      timer_trigger_pkg::MM_REF0: trig_next = compare_reference[0];
      timer_trigger_pkg::MM_REF1: trig_next = compare_reference[1];
      timer_trigger_pkg::MM_REF2: trig_next = compare_reference[2];
      timer_trigger_pkg::MM_REF3: trig_next = compare_reference[3];
      default: trig_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  assign trigger_output = trig_reg;

endmodule : trigger_output_select

`default_nettype wire

// [test/slave_timer_model.sv]
`timescale 1ns/1ps
`default_nettype none

module slave_timer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger_output,
  output logic [7:0] start_count
);
  logic prev_reg;
  logic prev_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;

  // Slave starts on a rising edge, so a held level counts once
  always_comb begin
    prev_next = trigger_output;
    count_next = count_reg + ((trigger_output && !prev_reg) ? 8'h01 : 8'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b0;
      count_reg <= 8'h00;
    end else begin
      prev_reg <= prev_next;
      count_reg <= count_next;
    end
  end

  assign start_count = count_reg;
endmodule : slave_timer_model

`default_nettype wire

// [test/tb_timer_master_trigger_select.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb_timer_master_trigger_select;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [10:0] src = 11'h000;
  logic [2:0] pins = 3'h0, cap_hi = 3'h0;
  wire logic awready, wready, bvalid, arready, rvalid, ch0_trig, trig_out;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] dma;
  wire logic [7:0] starts;
  int errors = 0;
  int checks = 0;
  // Source bits: counter reset, update gen, run, pause, trigger, capcmp0, update, refs
  logic [2:0] mode_tab [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [10:0] vec_tab [10] = '{11'h400, 11'h200, 11'h100, 11'h0C0, 11'h020, 11'h010, 11'h001, 11'h002,
    11'h004, 11'h008};
  logic [10:0] mine_tab [8] = '{11'h600, 11'h1C0, 11'h020, 11'h010, 11'h001, 11'h002, 11'h004, 11'h008};

  timer_master_trigger_select #(.CHANNELS(4)) DUT (
    .CLK_SYS(clk_sys), .RESET(reset),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .CHANNEL0_PIN(pins[0]), .CHANNEL1_PIN(pins[1]), .CHANNEL2_PIN(pins[2]),
    .COUNTER_RESET_EVENT(src[10]), .UPDATE_GENERATION_BIT(src[9]), .COUNTER_RUN_BIT(src[8]),
    .PAUSE_MODE(src[7]), .TRIGGER_INPUT(src[6]), .UPDATE_EVENT(src[4]),
    .CAPCMP_EVENT({cap_hi, src[5]}), .COMPARE_REFERENCE(src[3:0]),
    .CH0_TRIGGER_INPUT(ch0_trig), .TRIGGER_OUTPUT(trig_out), .DMA_REQUEST(dma)
  );

  slave_timer_model partner (.clk(clk_sys), .rst(reset), .trigger_output(trig_out), .start_count(starts));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // One-cycle source, then the output must drop again
  task automatic pulse(input logic [10:0] v, input logic exp);
    @(posedge clk_sys);
    src <= v;
    @(posedge clk_sys);
    src <= 11'h000;
    #1 `CHK("trigger_output", exp, trig_out)
    @(posedge clk_sys);
    #1 `CHK("trigger_output", 1'b0, trig_out)
  endtask : pulse

  task automatic dma_chk(input logic [3:0] c, input logic u, input logic [3:0] exp);
    @(posedge clk_sys);
    {cap_hi, src[5]} <= c;
    src[4] <= u;
    @(posedge clk_sys);
    {cap_hi, src[5]} <= 4'h0;
    src[4] <= 1'b0;
    #1 `CHK("dma_request", exp, dma)
  endtask : dma_chk

  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h04, 32'h00000000, 2'h0);
    wr(8'h04, 32'h000000F8, 4'hF, 2'h0);
    rd(8'h04, 32'h000000F8, 2'h0);
    wr(8'h04, 32'h00000000, 4'hE, 2'h0);
    rd(8'h04, 32'h000000F8, 2'h0);
    wr(8'h10, 32'h000000F8, 4'hF, 2'h2);
    rd(8'h10, 32'h00000000, 2'h2);
    for (int s = 0; s < 2; s++) begin
      wr(8'h04, {24'h000000, s[0], 7'h00}, 4'h1, 2'h0);
      for (int p = 0; p < 8; p++) begin
        @(posedge clk_sys);
        pins <= p[2:0];
        @(posedge clk_sys);
        #1 `CHK("ch0_trigger_input", s[0] ? ^p[2:0] : p[0], ch0_trig)
      end
      // All pins high: both selections give a high trigger input in the status word
      rd(8'h0C, 32'h00000020, 2'h0);
    end
    for (int i = 0; i < 10; i++) begin
      wr(8'h04, {25'h0000000, mode_tab[i], 4'h0}, 4'h1, 2'h0);
      @(posedge clk_sys);
      pulse(11'h7FF & ~mine_tab[mode_tab[i]], 1'b0);
      pulse(vec_tab[i], 1'b1);
    end
    `CHK("slave_starts", 8'h0A, starts)
    wr(8'h04, 32'h00000000, 4'h1, 2'h0);
    dma_chk(4'h5, 1'b1, 4'h5);
    dma_chk(4'h0, 1'b1, 4'h0);
    wr(8'h04, 32'h00000008, 4'h1, 2'h0);
    dma_chk(4'hF, 1'b0, 4'h0);
    dma_chk(4'h0, 1'b1, 4'hF);
    complete_run();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : tb_timer_master_trigger_select

`default_nettype wire
